// *** cmd_if.sv ***
// load, shift and data signals between the command port and its shift register
`timescale 1ns/1ns
interface cmd_if;
    logic load;
    logic [15:0] load_word;
    logic shift;
    logic bit_in;
    logic [15:0] word;
    logic bit_out;
    modport ctrl (output load, output load_word, output shift, output bit_in,
        input word, input bit_out);
    modport sreg (input load, input load_word, input shift, input bit_in,
        output word, output bit_out);
endinterface

// *** cmd_shifter.sv ***
// sixteen-bit command shift register, upper byte first
`timescale 1ns/1ns
module cmd_shifter
(
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    cmd_if.sreg sr // load and shift controls
);
    logic [15:0] data_reg;
    logic [15:0] data_next;

    always_comb
    begin
        data_next = data_reg;
        if (sr.load)
        begin
            data_next = sr.load_word;
        end
        else if (sr.shift)
        begin
            data_next = {data_reg[14:0], sr.bit_in};
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            data_reg <= 16'h0000;
        end
        else
        begin
            data_reg <= data_next;
        end
    end

    assign sr.word = data_reg;
    assign sr.bit_out = data_reg[15];
endmodule

// *** ctrl_model.sv ***
// behavioural disk controller driving the serial command handshake
`timescale 1ns/1ns
module ctrl_model
(
    input wire logic clk, // system clock
    input wire logic ack, // bit taken
    input wire logic reply, // serial reply bit
    output logic req, // bit valid
    output logic data // command bit
);
    initial
    begin
        req = 1'b0;
        data = 1'b0;
    end
    // sends nbits msb first; rx holds the reply bit seen before each take
    task automatic xfer(input logic [16:0] tx, input int nbits,
        output logic [16:0] rx, output int acks);
        int n;
        int k;
        rx = 17'h00000;
        acks = 0;
        for (k = 0; k < nbits; k++)
        begin
            @(posedge clk);
            #1;
            req = 1'b1;
            data = tx[16-k];
            @(negedge clk);
            rx[16-k] = reply;
            n = 0;
            while (ack !== 1'b1 && n < 8)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            if (ack === 1'b1)
                acks++;
            req = 1'b0;
            // released line shows the inverse of the last bit
            data = ~data;
            n = 0;
            while (ack !== 1'b0 && n < 8)
            begin
                @(posedge clk);
                #1;
                n++;
            end
        end
    endtask
endmodule

// *** disk_drive_select_command_port_bench.sv ***
// self-checking bench for the drive select and command port
`timescale 1ns/1ns
module disk_drive_select_command_port_bench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [2:0] strap = 3'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic wp = 1'b0;
    logic cos = 1'b0;
    logic [15:0] rword = 16'h0000;
    logic rload = 1'b0;
    logic req, data, usel, ack, rdata, rgo, wgo, wflt, perr, iflt, attn, rdy, rwant;
    logic [7:0] upper, lower;
    int mismatches = 0;
    int check_count = 0;
    int ready_cnt = 0;
    int cycles = 0;
    int acks;
    int cnt0;
    integer seed;
    logic [15:0] w;
    logic [16:0] rx;
    logic prev;

    initial
    begin
        forever #20 clock = ~clock;
    end

    unit_cmd_port i_unit_cmd_port (.CLOCK(clock), .RST(rst), .CONTROLLER_UNIT_SELECT(sel),
        .STRAPPED_UNIT_NUMBER(strap), .XFER_REQ(req), .CMD_DATA(data), .READ_GATE_IN(rd),
        .WRITE_GATE_IN(wr), .WRITE_PROTECT(wp), .CHANGE_OF_STATUS(cos), .REPLY_WORD(rword),
        .REPLY_LOAD(rload), .UNIT_SELECTED(usel), .XFER_ACK(ack), .REPLY_DATA(rdata),
        .READ_GATE_OUT(rgo), .WRITE_GATE_OUT(wgo), .WRITE_FAULT_FLAG(wflt),
        .PARITY_ERROR(perr), .INTERFACE_FAULT(iflt), .ATTENTION_OUT(attn),
        .CMD_READY(rdy), .CMD_UPPER(upper), .CMD_LOWER(lower), .REPLY_WANTED(rwant));

    ctrl_model i_ctrl_model (.clk(clock), .ack(ack), .reply(rdata), .req(req), .data(data));

    always @(negedge clock)
    begin
        cycles++;
        if (rdy === 1'b1)
            ready_cnt++;
        if (cycles == 20000)
        begin
            mismatches++;
            $display("timeout reached");
            summarize();
        end
    end

    function automatic logic exp_sel(input logic [2:0] s, input logic [2:0] n);
        return (s === n) && (s !== unit_pkg::SEL_NONE);
    endfunction

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clock);
            #1;
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // good odd parity unless bad is set
    task automatic send(input logic [15:0] cw, input logic bad);
        i_ctrl_model.xfer({cw, (~^cw) ^ bad}, 17, rx, acks);
        tick(2);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        seed = 32'h21715b03;
        tick(5);
        rst = 1'b0;
        tick(1);
        prev = 1'b0;
        for (int i = 0; i < 64; i++)
        begin
            sel = i[5:3];
            strap = i[2:0];
            chk(usel, prev);
            tick(1);
            prev = exp_sel(sel, strap);
            chk(usel, prev);
        end
        $display("test select done");
        sel = 3'h2;
        strap = 3'h5;
        tick(2);
        cnt0 = ready_cnt;
        send(16'h1234, 1'b0);
        chk(acks, 0);
        chk(ready_cnt, cnt0);
        sel = 3'h5;
        tick(2);
        for (int i = 0; i < 12; i++)
        begin
            w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($random(seed));
            if (w[15:13] == 3'h1)
                w[15] = 1'b1;
            cnt0 = ready_cnt;
            send(w, 1'b0);
            chk(acks, 17);
            chk(ready_cnt, cnt0 + 1);
            chk({upper, lower}, w);
            chk(perr, 1'b0);
        end
        cnt0 = ready_cnt;
        send(16'h4321, 1'b1);
        chk(ready_cnt, cnt0);
        chk(perr, 1'b1);
        chk(attn, 1'b1);
        send(16'h4321, 1'b0);
        chk(perr, 1'b0);
        $display("test command done");
        for (int f = 2; f < 4; f++)
        begin
            send({f[3:0], 12'($random(seed))}, 1'b0);
            chk(rwant, 1'b1);
            rword = 16'($random(seed));
            rload = 1'b1;
            tick(1);
            rload = 1'b0;
            i_ctrl_model.xfer(17'($random(seed)), 17, rx, acks);
            tick(2);
            chk(rx, {rword, ~^rword});
            chk(acks, 17);
            chk(rwant, 1'b0);
        end
        $display("test reply done");
        i_ctrl_model.xfer(17'h1ffff, 5, rx, acks);
        sel = 3'h0;
        tick(3);
        chk(iflt, 1'b1);
        chk(attn, 1'b1);
        rd = 1'b1;
        wr = 1'b1;
        tick(3);
        chk(wflt, 1'b0);
        sel = 3'h5;
        rd = 1'b0;
        wr = 1'b0;
        tick(2);
        send(16'h6789, 1'b0);
        chk(iflt, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            {rd, wr, wp} = i[2:0];
            tick(1);
            chk(rgo, rd);
            chk(wgo, wr & ~wp);
        end
        rd = 1'b0;
        wr = 1'b0;
        tick(3);
        chk(wflt, 1'b1);
        chk(attn, 1'b1);
        send(16'h5000, 1'b0);
        chk(wflt, 1'b0);
        chk(attn, 1'b0);
        cos = 1'b1;
        tick(3);
        chk(attn, 1'b1);
        cos = 1'b0;
        tick(3);
        chk(attn, 1'b0);
        $display("test gates and attention done");
        summarize();
    end
endmodule

// *** unit_cmd_port.sv ***
// drive select, gate control, serial command port and attention
`timescale 1ns/1ns
module unit_cmd_port
(
    input wire logic CLOCK, // system clock
    input wire logic RST, // synchronous reset, active high
    input wire logic [2:0] CONTROLLER_UNIT_SELECT, // select code from controller
    input wire logic [2:0] STRAPPED_UNIT_NUMBER, // strapped unit number
    input wire logic XFER_REQ, // controller bit valid
    input wire logic CMD_DATA, // serial command bit
    input wire logic READ_GATE_IN, // read gate request
    input wire logic WRITE_GATE_IN, // write gate request
    input wire logic WRITE_PROTECT, // write protect
    input wire logic CHANGE_OF_STATUS, // external status change
    input wire logic [15:0] REPLY_WORD, // data word from microcontroller
    input wire logic REPLY_LOAD, // pulse: load reply word
    output logic UNIT_SELECTED, // drive selected
    output logic XFER_ACK, // bit taken
    output logic REPLY_DATA, // serial reply bit
    output logic READ_GATE_OUT, // read gate to drive
    output logic WRITE_GATE_OUT, // write gate to drive
    output logic WRITE_FAULT_FLAG, // write fault
    output logic PARITY_ERROR, // parity error on last command
    output logic INTERFACE_FAULT, // handshake stopped early
    output logic ATTENTION_OUT, // attention to controller
    output logic CMD_READY, // pulse: command word valid
    output logic [7:0] CMD_UPPER, // upper command byte
    output logic [7:0] CMD_LOWER, // lower command byte
    output logic REPLY_WANTED // reply word awaited
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RECV = 2'b01,
        ST_WAIT = 2'b10,
        ST_SEND = 2'b11
    } port_e;

    cmd_if sif();
    cmd_shifter u_shift (.clk(CLOCK), .rst(RST), .sr(sif.sreg));

    port_e st_reg, st_next;
    logic [4:0] cnt_reg, cnt_next;
    logic par_reg, par_next;
    logic req_reg, req_next;
    logic sel_reg, sel_next;
    logic ack_reg, ack_next;
    logic rdo_reg, rdo_next;
    logic rg_reg, rg_next;
    logic wg_reg, wg_next;
    logic wf_reg, wf_next;
    logic pe_reg, pe_next;
    logic if_reg, if_next;
    logic att_reg, att_next;
    logic rdy_reg, rdy_next;
    logic want_reg, want_next;
    logic [7:0] up_reg, up_next;
    logic [7:0] lo_reg, lo_next;
    logic take;

    always_comb
    begin
        sel_next = (CONTROLLER_UNIT_SELECT == STRAPPED_UNIT_NUMBER)
            && (CONTROLLER_UNIT_SELECT != unit_pkg::SEL_NONE);
        rg_next = READ_GATE_IN;
        wg_next = WRITE_GATE_IN && !WRITE_PROTECT;
        take = XFER_REQ && !req_reg && sel_reg;
        st_next = st_reg;
        cnt_next = cnt_reg;
        par_next = par_reg;
        ack_next = XFER_REQ && sel_reg && (ack_reg || take);
        rdo_next = rdo_reg;
        pe_next = pe_reg;
        if_next = if_reg;
        rdy_next = 1'b0;
        want_next = want_reg;
        up_next = up_reg;
        lo_next = lo_reg;
        wf_next = wf_reg || (sel_reg && READ_GATE_IN && WRITE_GATE_IN);
        sif.load = 1'b0;
        sif.load_word = REPLY_WORD;
        sif.shift = 1'b0;
        sif.bit_in = CMD_DATA;
        case (st_reg)
            ST_IDLE, ST_RECV:
            begin
                if (!sel_reg && st_reg == ST_RECV)
                begin
                    if_next = 1'b1;
                    st_next = ST_IDLE;
                    cnt_next = unit_pkg::CNT_ZERO;
                    par_next = 1'b0; // a cut frame must not skew the next parity
                end
                else if (take)
                begin
                    par_next = par_reg ^ CMD_DATA;
                    if (cnt_reg == unit_pkg::LAST_BIT)
                    begin
                        pe_next = !(par_reg ^ CMD_DATA); // odd parity
                        cnt_next = unit_pkg::CNT_ZERO;
                        par_next = 1'b0;
                        st_next = ST_IDLE;
                        if (par_reg ^ CMD_DATA)
                        begin
                            up_next = sif.word[15:8];
                            lo_next = sif.word[7:0];
                            rdy_next = 1'b1;
                            if_next = 1'b0;
                            if (sif.word[unit_pkg::FUNC_HI:unit_pkg::FUNC_LO]
                                == unit_pkg::FUNC_CONTROL
                                && sif.word[unit_pkg::MOD_HI:unit_pkg::MOD_LO]
                                == unit_pkg::MOD_RESET)
                            begin
                                wf_next = sel_reg && READ_GATE_IN && WRITE_GATE_IN;
                            end
                            if (sif.word[unit_pkg::FUNC_HI:unit_pkg::FUNC_LO]
                                == unit_pkg::FUNC_REQ_STATUS
                                || sif.word[unit_pkg::FUNC_HI:unit_pkg::FUNC_LO]
                                == unit_pkg::FUNC_REQ_CONFIG)
                            begin
                                want_next = 1'b1;
                                st_next = ST_WAIT;
                            end
                        end
                    end
                    else
                    begin
                        sif.shift = 1'b1;
                        cnt_next = cnt_reg + 5'h01;
                        st_next = ST_RECV;
                    end
                end
            end
            ST_WAIT:
            begin
                if (REPLY_LOAD)
                begin
                    sif.load = 1'b1;
                    want_next = 1'b0;
                    par_next = 1'b1; // odd parity seed
                    rdo_next = REPLY_WORD[15];
                    st_next = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (!sel_reg)
                begin
                    if_next = 1'b1;
                    st_next = ST_IDLE;
                    cnt_next = unit_pkg::CNT_ZERO;
                    par_next = 1'b0;
                end
                else if (take)
                begin
                    if (cnt_reg == unit_pkg::LAST_BIT)
                    begin
                        cnt_next = unit_pkg::CNT_ZERO;
                        par_next = 1'b0;
                        st_next = ST_IDLE;
                    end
                    else
                    begin
                        par_next = par_reg ^ sif.bit_out;
                        sif.shift = 1'b1;
                        sif.bit_in = 1'b0;
                        cnt_next = cnt_reg + 5'h01;
                        rdo_next = (cnt_reg == 5'h0f) ? (par_reg ^ sif.bit_out)
                            : sif.word[14];
                    end
                end
            end
            default:
            begin
                st_next = ST_IDLE;
            end
        endcase
        att_next = wf_reg || pe_reg || if_reg || CHANGE_OF_STATUS;
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            st_reg <= ST_IDLE;
            cnt_reg <= 5'h00;
            par_reg <= 1'b0;
            req_reg <= 1'b0;
            sel_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdo_reg <= 1'b0;
            rg_reg <= 1'b0;
            wg_reg <= 1'b0;
            wf_reg <= 1'b0;
            pe_reg <= 1'b0;
            if_reg <= 1'b0;
            att_reg <= 1'b0;
            rdy_reg <= 1'b0;
            want_reg <= 1'b0;
            up_reg <= 8'h00;
            lo_reg <= 8'h00;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            par_reg <= par_next;
            req_reg <= XFER_REQ;
            sel_reg <= sel_next;
            ack_reg <= ack_next;
            rdo_reg <= rdo_next;
            rg_reg <= rg_next;
            wg_reg <= wg_next;
            wf_reg <= wf_next;
            pe_reg <= pe_next;
            if_reg <= if_next;
            att_reg <= att_next;
            rdy_reg <= rdy_next;
            want_reg <= want_next;
            up_reg <= up_next;
            lo_reg <= lo_next;
        end
    end

    assign UNIT_SELECTED = sel_reg;
    assign XFER_ACK = ack_reg;
    assign REPLY_DATA = rdo_reg;
    assign READ_GATE_OUT = rg_reg;
    assign WRITE_GATE_OUT = wg_reg;
    assign WRITE_FAULT_FLAG = wf_reg;
    assign PARITY_ERROR = pe_reg;
    assign INTERFACE_FAULT = if_reg;
    assign ATTENTION_OUT = att_reg;
    assign CMD_READY = rdy_reg;
    assign CMD_UPPER = up_reg;
    assign CMD_LOWER = lo_reg;
    assign REPLY_WANTED = want_reg;

    property p_select;
        @(posedge CLOCK) disable iff (RST)
        1'b1 |=> UNIT_SELECTED == ($past(CONTROLLER_UNIT_SELECT) == $past(STRAPPED_UNIT_NUMBER)
            && $past(CONTROLLER_UNIT_SELECT) != 3'h0);
    endproperty
    a_select: assert property (p_select) else $error("unit select mismatch");

    property p_zero;
        @(posedge CLOCK) disable iff (RST)
        CONTROLLER_UNIT_SELECT == 3'h0 |=> !UNIT_SELECTED;
    endproperty
    a_zero: assert property (p_zero) else $error("code zero selected a unit");

    property p_ignore;
        @(posedge CLOCK) disable iff (RST)
        !sel_reg && XFER_REQ |=> !XFER_ACK;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ack while not selected");

    property p_ack;
        @(posedge CLOCK) disable iff (RST)
        sel_reg && XFER_REQ && !req_reg && sel_next |=> XFER_ACK;
    endproperty
    a_ack: assert property (p_ack) else $error("bit not acknowledged");

    property p_wprot;
        @(posedge CLOCK) disable iff (RST)
        WRITE_PROTECT |=> !WRITE_GATE_OUT;
    endproperty
    a_wprot: assert property (p_wprot) else $error("write gate under protect");

    property p_rgate;
        @(posedge CLOCK) disable iff (RST)
        1'b1 |=> READ_GATE_OUT == $past(READ_GATE_IN);
    endproperty
    a_rgate: assert property (p_rgate) else $error("read gate not passed");

    sequence s_both;
        sel_reg && READ_GATE_IN && WRITE_GATE_IN;
    endsequence
    property p_wfault;
        @(posedge CLOCK) disable iff (RST)
        s_both |=> WRITE_FAULT_FLAG ##1 ATTENTION_OUT;
    endproperty
    a_wfault: assert property (p_wfault) else $error("write fault not raised");

    property p_attention_out;
        @(posedge CLOCK) disable iff (RST)
        CHANGE_OF_STATUS |=> ATTENTION_OUT;
    endproperty
    a_attention_out: assert property (p_attention_out) else $error("attention missing");

    property p_bytes;
        @(posedge CLOCK) disable iff (RST)
        CMD_READY |-> {CMD_UPPER, CMD_LOWER} == $past(sif.word);
    endproperty
    a_bytes: assert property (p_bytes) else $error("command bytes wrong");
endmodule

// *** unit_pkg.sv ***
// constants for the drive select and command port
package unit_pkg;
    localparam int SEL_W = 3;
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam int CMD_BITS = 17;
    localparam logic [4:0] LAST_BIT = 5'h10;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [3:0] FUNC_REQ_STATUS = 4'h2;
    localparam logic [3:0] FUNC_REQ_CONFIG = 4'h3;
    localparam logic [3:0] FUNC_CONTROL = 4'h5;
    localparam logic [3:0] MOD_RESET = 4'h0;
    localparam int FUNC_HI = 15;
    localparam int FUNC_LO = 12;
    localparam int MOD_HI = 11;
    localparam int MOD_LO = 8;
endpackage
